// ---- src/rqc_pkg.sv ----
// Constants for the receive-queue command register block.
// Assumes the host bus decoder supplies register hits and strobes in the core clock domain.
// Contract
// RULE1: Threshold status flags refresh only on host write-one to interrupt status bit 13.
// RULE2: Frame-count flag bit 10 set when frame count caused the interrupt.
// RULE3: Bit 9 enables two pad bytes before each frame header.
// RULE4: Bit 7 enables interrupt when queue duration exceeds its threshold.
// RULE5: Bit 6 enables interrupt when queued bytes exceed their threshold.
// RULE6: Bit 5 enables interrupt when queued frames exceed their threshold.
// RULE7: Bit 4 set advances read pointer after a frame is fully read.
// RULE8: Writing one to bit 3 starts DMA using strobes only; the code also gates both strobes with host_address_enable_in.
// RULE9: In DMA mode only this register stays accessible.
// RULE10: Host clears bit 3 after DMA before touching other registers.
// RULE11: Writing one to bit 0 frees the current error frame's memory.
// RULE12: Bit 0 clears itself once the frame memory is freed.
// RULE13: Host polls bit 0 until zero before handling another frame.
// RULE14: Duration flag bit 12 set when duration caused the interrupt.
// RULE15: Byte-count flag bit 11 set when byte count caused the interrupt.
// RULE16: Thresholds arrive as inputs and are compared continuously with live counts.
// RULE17: Enabled conditions merge into one request; cause latched in flags.
`default_nettype none

package rqc_pkg;
    // ==========================================================
    // Register layout
    localparam int RQC_REG_W = 16;
    localparam int RQC_BIT_DUR_FLAG = 12;
    localparam int RQC_BIT_BYTE_FLAG = 11;
    localparam int RQC_BIT_FRM_FLAG = 10;
    localparam int RQC_BIT_ALIGN = 9;
    localparam int RQC_BIT_DUR_EN = 7;
    localparam int RQC_BIT_BYTE_EN = 6;
    localparam int RQC_BIT_FRM_EN = 5;
    localparam int RQC_BIT_AUTO_DEQ = 4;
    localparam int RQC_BIT_DMA_START = 3;
    localparam int RQC_BIT_RELEASE = 0;
    // Bit used in the interrupt status register for the receive interrupt
    localparam int RQC_ISR_RX_BIT = 13;
    // ==========================================================
    // Reset values
    localparam logic RQC_RST_BIT = 1'b0;
    localparam logic [RQC_REG_W-1:0] RQC_RST_WORD = 16'h0000;
endpackage : rqc_pkg

`default_nettype wire

// ---- src/rqc_rx_queue_command.sv ----
// Receive-queue command register: threshold interrupt control, DMA mode, error release.
// Assumes all inputs are synchronous to clock_in and write strobes last one cycle.
`default_nettype none

module rqc_rx_queue_command
    import rqc_pkg::*;
#(
    parameter int DUR_W = 16,
    parameter int BYTE_W = 16,
    parameter int FRM_W = 8
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic reg_write_in,
    input wire logic [RQC_REG_W-1:0] reg_wdata_in,
    output logic [RQC_REG_W-1:0] reg_rdata_out,
    input wire logic addr_hit_cmd_in,
    output logic reg_access_allow_out,
    input wire logic isr_write_in,
    input wire logic [RQC_REG_W-1:0] isr_wdata_in,
    input wire logic [DUR_W-1:0] rx_duration_threshold_in,
    input wire logic [BYTE_W-1:0] rx_byte_threshold_in,
    input wire logic [FRM_W-1:0] rx_frame_threshold_in,
    input wire logic [DUR_W-1:0] queue_duration_in,
    input wire logic [BYTE_W-1:0] queue_bytes_in,
    input wire logic [FRM_W-1:0] queue_frames_in,
    output logic rx_irq_out,
    output logic ip_header_align_enable_out,
    input wire logic frame_read_done_in,
    output logic dequeue_advance_out,
    input wire logic host_address_enable_in,
    input wire logic host_read_strobe_n_in,
    input wire logic host_write_strobe_n_in,
    output logic dma_active_out,
    output logic dma_rx_read_out,
    output logic dma_tx_write_out,
    output logic error_frame_release_out,
    input wire logic release_done_in
);
    // ==========================================================
    // State
    typedef struct packed {
        logic dur_flag;
        logic byte_flag;
        logic frm_flag;
        logic align;
        logic dur_en;
        logic byte_en;
        logic frm_en;
        logic auto_deq;
        logic dma;
        logic release_busy;
        logic release_pulse;
        logic deq_pulse;
    } rqc_state_s;

    rqc_state_s state_reg;
    rqc_state_s state_next;

    logic dur_hit;
    logic byte_hit;
    logic frm_hit;
    logic isr_refresh;
    logic cmd_write;

    // Live comparisons, never sampled, so the request tracks the queue at once
    assign dur_hit = state_reg.dur_en && (queue_duration_in > rx_duration_threshold_in); // [RULE4] [RULE16]
    assign byte_hit = state_reg.byte_en && (queue_bytes_in > rx_byte_threshold_in); // [RULE5] [RULE16]
    assign frm_hit = state_reg.frm_en && (queue_frames_in > rx_frame_threshold_in); // [RULE6] [RULE16]
    assign isr_refresh = isr_write_in && isr_wdata_in[RQC_ISR_RX_BIT];
    // Command register writes stay allowed in DMA mode
    assign cmd_write = reg_write_in && addr_hit_cmd_in;

    // ==========================================================
    // Next-state logic
    always_comb begin
        state_next = state_reg;
        state_next.release_pulse = 1'b0;
        state_next.deq_pulse = 1'b0;
        // Flags only follow the live causes at the acknowledge write
        if (isr_refresh) begin // [RULE1]
            state_next.dur_flag = dur_hit; // [RULE14] [RULE17]
            state_next.byte_flag = byte_hit; // [RULE15] [RULE17]
            state_next.frm_flag = frm_hit; // [RULE2] [RULE17]
        end
        // Self-clear after memory freed; a new request below wins
        if (state_reg.release_busy && release_done_in) begin
            state_next.release_busy = 1'b0; // [RULE12]
        end
        if (cmd_write) begin
            state_next.align = reg_wdata_in[RQC_BIT_ALIGN]; // [RULE3]
            state_next.dur_en = reg_wdata_in[RQC_BIT_DUR_EN];
            state_next.byte_en = reg_wdata_in[RQC_BIT_BYTE_EN];
            state_next.frm_en = reg_wdata_in[RQC_BIT_FRM_EN];
            state_next.auto_deq = reg_wdata_in[RQC_BIT_AUTO_DEQ];
            state_next.dma = reg_wdata_in[RQC_BIT_DMA_START]; // [RULE8] [RULE10]
            if (reg_wdata_in[RQC_BIT_RELEASE]) begin
                state_next.release_busy = 1'b1; // [RULE11]
                state_next.release_pulse = !state_reg.release_busy;
            end
        end
        if (state_reg.auto_deq && frame_read_done_in) begin
            state_next.deq_pulse = 1'b1; // [RULE7]
        end
    end

    // Register the whole state
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Outputs
    always_comb begin
        reg_rdata_out = RQC_RST_WORD;
        reg_rdata_out[RQC_BIT_DUR_FLAG] = state_reg.dur_flag;
        reg_rdata_out[RQC_BIT_BYTE_FLAG] = state_reg.byte_flag;
        reg_rdata_out[RQC_BIT_FRM_FLAG] = state_reg.frm_flag;
        reg_rdata_out[RQC_BIT_ALIGN] = state_reg.align;
        reg_rdata_out[RQC_BIT_DUR_EN] = state_reg.dur_en;
        reg_rdata_out[RQC_BIT_BYTE_EN] = state_reg.byte_en;
        reg_rdata_out[RQC_BIT_FRM_EN] = state_reg.frm_en;
        reg_rdata_out[RQC_BIT_AUTO_DEQ] = state_reg.auto_deq;
        // DMA start is write-only and reads back zero
        reg_rdata_out[RQC_BIT_RELEASE] = state_reg.release_busy;
    end

    assign rx_irq_out = dur_hit || byte_hit || frm_hit; // [RULE17]
    assign ip_header_align_enable_out = state_reg.align; // [RULE3]
    assign dequeue_advance_out = state_reg.deq_pulse;
    assign dma_active_out = state_reg.dma;
    // Other registers are fenced off while DMA runs
    assign reg_access_allow_out = !state_reg.dma || addr_hit_cmd_in; // [RULE9]
    // Address enable gates the strobes in DMA mode; byte enables are not looked at
    assign dma_rx_read_out = state_reg.dma && host_address_enable_in && !host_read_strobe_n_in; // [RULE8]
    assign dma_tx_write_out = state_reg.dma && host_address_enable_in && !host_write_strobe_n_in;
    assign error_frame_release_out = state_reg.release_pulse;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_release_req;
        cmd_write && reg_wdata_in[RQC_BIT_RELEASE] && !state_reg.release_busy;
    endsequence
    sequence s_release_done;
        state_reg.release_busy && release_done_in && !(cmd_write && reg_wdata_in[RQC_BIT_RELEASE]);
    endsequence

    a_flags_hold_still: assert property (!isr_refresh |=> // [RULE1]
        $stable(reg_rdata_out[RQC_BIT_DUR_FLAG:RQC_BIT_FRM_FLAG]))
        else $error("flags changed without refresh");
    a_frame_flag_set: assert property (isr_refresh && frm_hit |=> // [RULE2]
        reg_rdata_out[RQC_BIT_FRM_FLAG])
        else $error("frame flag not set");
    // A refresh with the cause gone must drop the flag, not keep an old cause
    a_frame_flag_clear: assert property (isr_refresh && !frm_hit |=> // [RULE2]
        !reg_rdata_out[RQC_BIT_FRM_FLAG])
        else $error("frame flag not cleared");
    a_align_follows_write: assert property (cmd_write |=> // [RULE3]
        ip_header_align_enable_out == $past(reg_wdata_in[RQC_BIT_ALIGN]))
        else $error("align enable wrong");
    a_align_holds: assert property (!cmd_write |=> // [RULE3]
        $stable(ip_header_align_enable_out))
        else $error("align enable drifted");
    a_duration_irq_raise: assert property (state_reg.dur_en && // [RULE4]
        queue_duration_in > rx_duration_threshold_in |-> rx_irq_out)
        else $error("duration irq missing");
    a_byte_irq_raise: assert property (state_reg.byte_en && // [RULE5]
        queue_bytes_in > rx_byte_threshold_in |-> rx_irq_out)
        else $error("byte irq missing");
    a_frame_irq_raise: assert property (state_reg.frm_en && // [RULE6]
        queue_frames_in > rx_frame_threshold_in |-> rx_irq_out)
        else $error("frame irq missing");
    a_dequeue_advance_once: assert property (state_reg.auto_deq && frame_read_done_in // [RULE7]
        |=> dequeue_advance_out)
        else $error("dequeue not advanced");
    a_dequeue_needs_read: assert property (!(state_reg.auto_deq && frame_read_done_in) // [RULE7]
        |=> !dequeue_advance_out)
        else $error("dequeue without finished read");
    a_dma_start_mode: assert property (cmd_write && reg_wdata_in[RQC_BIT_DMA_START] // [RULE8]
        |=> dma_active_out ##0 (host_read_strobe_n_in || !host_address_enable_in
        || dma_rx_read_out))
        else $error("dma mode not entered");
    a_dma_exit_write: assert property (cmd_write && !reg_wdata_in[RQC_BIT_DMA_START] // [RULE8]
        |=> !dma_active_out)
        else $error("dma mode not left");
    a_dma_idle_quiet: assert property (!dma_active_out // [RULE8]
        |-> !dma_rx_read_out && !dma_tx_write_out)
        else $error("queue strobe outside dma");
    a_dma_write_map: assert property (dma_active_out && host_address_enable_in // [RULE8]
        && !host_write_strobe_n_in |-> dma_tx_write_out)
        else $error("dma write not served");
    a_dma_block_regs: assert property (dma_active_out && !addr_hit_cmd_in // [RULE9]
        |-> !reg_access_allow_out)
        else $error("register not blocked");
    a_release_start_pulse: assert property (s_release_req |=> // [RULE11]
        error_frame_release_out && reg_rdata_out[RQC_BIT_RELEASE] ##1 !error_frame_release_out)
        else $error("release not started");
    a_release_busy_quiet: assert property (state_reg.release_busy |=> // [RULE11]
        !error_frame_release_out)
        else $error("second release pulse");
    a_release_set_wins: assert property (cmd_write && reg_wdata_in[RQC_BIT_RELEASE] |=> // [RULE11]
        reg_rdata_out[RQC_BIT_RELEASE])
        else $error("release request lost");
    a_release_self_clear: assert property (s_release_done |=> // [RULE12]
        !reg_rdata_out[RQC_BIT_RELEASE])
        else $error("release bit not cleared");
    a_duration_flag_set: assert property (isr_refresh && dur_hit |=> // [RULE14]
        reg_rdata_out[RQC_BIT_DUR_FLAG])
        else $error("duration flag not set");
    a_byte_flag_set: assert property (isr_refresh && byte_hit |=> // [RULE15]
        reg_rdata_out[RQC_BIT_BYTE_FLAG])
        else $error("byte flag not set");
    a_irq_needs_enable: assert property (!state_reg.dur_en && !state_reg.byte_en // [RULE17]
        && !state_reg.frm_en |-> !rx_irq_out)
        else $error("irq without enable");
endmodule : rqc_rx_queue_command

`default_nettype wire

// ---- test/rqc_host_model.sv ----
// Host side of the bus: address enable plus one active-low strobe per request.
// Assumes the bench raises go_rd_in or go_wr_in for one cycle, synchronous to clock_in.
`default_nettype none
module rqc_host_model (
    input wire logic clock_in,
    input wire logic go_rd_in,
    input wire logic go_wr_in,
    output var logic aen_out = 1'b0,
    output var logic rd_n_out = 1'b1,
    output var logic wr_n_out = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Strobes change only after an edge; read wins a clash so both never fall together
    always @(posedge clock_in) begin
        aen_out <= go_rd_in | go_wr_in;
        rd_n_out <= ~go_rd_in;
        wr_n_out <= ~(go_wr_in & ~go_rd_in);
    end
endmodule : rqc_host_model
`default_nettype wire

// ---- test/rqc_rx_queue_command_tb.sv ----
// Self-checking bench for the receive-queue command register.
// Assumes the design package and the host model are compiled first.
`default_nettype none
module rqc_rx_queue_command_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 0, rst_n_in = 0, reg_write_in = 0, addr_hit_cmd_in = 0, isr_write_in = 0;
    logic frame_read_done_in = 0, release_done_in = 0, go_rd = 0, go_wr = 0;
    logic host_address_enable_in, host_read_strobe_n_in, host_write_strobe_n_in;
    logic [15:0] reg_wdata_in = 0, isr_wdata_in = 0, reg_rdata_out, f;
    logic [15:0] rx_duration_threshold_in = 16'h5, rx_byte_threshold_in = 16'h5;
    logic [15:0] queue_duration_in = 16'h5, queue_bytes_in = 16'h5;
    logic [7:0] rx_frame_threshold_in = 8'h5, queue_frames_in = 8'h5;
    logic reg_access_allow_out, rx_irq_out, ip_header_align_enable_out, dequeue_advance_out;
    logic dma_active_out, dma_rx_read_out, dma_tx_write_out, error_frame_release_out;
    int errors = 0, checked = 0, cycles = 0;
    rqc_rx_queue_command i_dut (.clock_in, .rst_n_in, .reg_write_in, .reg_wdata_in,
        .reg_rdata_out, .addr_hit_cmd_in, .reg_access_allow_out, .isr_write_in, .isr_wdata_in,
        .rx_duration_threshold_in, .rx_byte_threshold_in, .rx_frame_threshold_in,
        .queue_duration_in, .queue_bytes_in, .queue_frames_in, .rx_irq_out,
        .ip_header_align_enable_out, .frame_read_done_in, .dequeue_advance_out,
        .host_address_enable_in, .host_read_strobe_n_in, .host_write_strobe_n_in,
        .dma_active_out, .dma_rx_read_out, .dma_tx_write_out, .error_frame_release_out,
        .release_done_in);
    rqc_host_model i_host (.clock_in, .go_rd_in(go_rd), .go_wr_in(go_wr),
        .aen_out(host_address_enable_in), .rd_n_out(host_read_strobe_n_in),
        .wr_n_out(host_write_strobe_n_in));
    // ==========================================
    // Clock and hang guard; the whole run needs well under 300 cycles
    always #5 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            finish_test();
        end
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Register and status writes: one-cycle strobe, result visible after the taking edge
    task wr(input logic [15:0] v);
        @(posedge clock_in);
        reg_write_in <= 1'b1;
        addr_hit_cmd_in <= 1'b1;
        reg_wdata_in <= v;
        @(posedge clock_in);
        reg_write_in <= 1'b0;
        addr_hit_cmd_in <= 1'b0;
        #1;
    endtask : wr
    task interrupt_status_reg(input logic [15:0] v);
        @(posedge clock_in);
        isr_write_in <= 1'b1;
        isr_wdata_in <= v;
        @(posedge clock_in);
        isr_write_in <= 1'b0;
        #1;
    endtask : interrupt_status_reg
    task host(input logic rd, input logic on);
        @(posedge clock_in);
        go_rd <= rd;
        go_wr <= ~rd;
        @(posedge clock_in);
        go_rd <= 1'b0;
        go_wr <= 1'b0;
        #1;
        chk({dma_rx_read_out, dma_tx_write_out}, on ? {rd, ~rd} : 2'b00);
    endtask : host
    // ==========================================
    // Scenarios
    task t_reset;
        chk(reg_rdata_out, 16'h0);
        chk({reg_access_allow_out, rx_irq_out, dma_active_out, error_frame_release_out}, 4'h8);
    endtask : t_reset
    // Reserved bits must not stick; no release or DMA from this pattern
    task t_align;
        wr(16'he306);
        chk(reg_rdata_out, 16'h0200);
        chk(ip_header_align_enable_out, 1'b1);
    endtask : t_align
    task t_deq;
        for (int j = 1; j >= 0; j--) begin
            wr(j[0] ? 16'h10 : 16'h0);
            @(posedge clock_in);
            frame_read_done_in <= 1'b1;
            @(posedge clock_in);
            frame_read_done_in <= 1'b0;
            #1;
            chk(dequeue_advance_out, j[0]);
            @(posedge clock_in);
            #1;
            chk(dequeue_advance_out, 1'b0);
        end
    endtask : t_deq
    task t_dma;
        wr(16'h0008);
        chk({dma_active_out, reg_access_allow_out, reg_rdata_out[3]}, 3'h4);
        host(1'b1, 1'b1);
        host(1'b0, 1'b1);
        @(posedge clock_in);
        addr_hit_cmd_in <= 1'b1;
        #1;
        chk(reg_access_allow_out, 1'b1);
        wr(16'h0000); // Host leaves DMA before other registers
        chk({dma_active_out, reg_access_allow_out}, 2'h1);
        host(1'b1, 1'b0); // Read strobe ignored outside DMA
    endtask : t_dma
    // Second write while busy must not launch another free request
    task t_rel;
        wr(16'h0001);
        chk(error_frame_release_out, 1'b1);
        chk(reg_rdata_out, 16'h0001);
        wr(16'h0001);
        chk(error_frame_release_out, 1'b0);
        chk(reg_rdata_out, 16'h0001);
        @(posedge clock_in);
        release_done_in <= 1'b1;
        @(posedge clock_in);
        release_done_in <= 1'b0;
        #1;
        chk(reg_rdata_out, 16'h0); // Host polls this to zero
    endtask : t_rel
    // Each measure just above its threshold in turn; equal values must not count
    task t_thresh;
        f = 16'h0;
        for (int i = 0; i < 3; i++) begin
            wr(16'h00e0);
            @(posedge clock_in);
            queue_duration_in <= (i == 0) ? 16'h6 : 16'h5;
            queue_bytes_in <= (i == 1) ? 16'h6 : 16'h5;
            queue_frames_in <= (i == 2) ? 8'h6 : 8'h5;
            @(posedge clock_in);
            #1;
            chk(rx_irq_out, 1'b1);
            interrupt_status_reg(16'hdfff);
            chk(reg_rdata_out, 16'h00e0 | f);
            interrupt_status_reg(16'h2000);
            f = 16'h1000 >> i;
            chk(reg_rdata_out, 16'h00e0 | f);
            wr(16'h0000);
            chk(rx_irq_out, 1'b0);
            chk(reg_rdata_out, f);
        end
    endtask : t_thresh
    task finish_test;
        if (errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (3) @(posedge clock_in);
        rst_n_in <= 1'b1;
        #1;
        t_reset();
        t_align();
        t_deq();
        t_dma();
        t_rel();
        t_thresh();
        finish_test();
    end
endmodule : rqc_rx_queue_command_tb
`default_nettype wire
